// *** shared/gauge_pm_pkg.sv ***
// Constants and types shared by the gauge power-mode controller
package gauge_pm_pkg;
  // Power states, exactly three of them plus one transitional calibration state
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_CALIB,
    ST_SLEEP,
    ST_DEEP
  } pm_state_t;

  localparam int CLK_MHZ = 125;
  // Longest line stretch when waking from deep idle, in microseconds
  localparam int STRETCH_MAX_US = 4000;
  localparam int STRETCH_CYC = STRETCH_MAX_US * CLK_MHZ;
  // Width of the deep-idle countdown and current values
  localparam int CUR_W = 16;
  localparam int WAIT_W = 16;
  localparam logic [1:0] SENSE_OFF = 2'h0;
  localparam logic [WAIT_W-1:0] WAIT_NONE = 16'h0000;
  localparam logic [2:0] RST_SYNC_INIT = 3'h0;
endpackage

// *** hdl/gauge_power_mode_control.sv ***
// Power-mode sequencer: normal, sleep and deep idle for a battery gauge
`timescale 1ns/1ps
module gauge_power_mode_control
  import gauge_pm_pkg::*;
#(
  parameter int STRETCH_CYCLES = STRETCH_CYC,
  parameter int PERIOD_CYCLES = 1000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Configuration
  input wire logic sleep_enable,
  input wire logic [CUR_W-1:0] sleep_current_level,
  input wire logic [WAIT_W-1:0] deep_idle_wait,
  input wire logic [1:0] sense_resistor_select,
  input wire logic wake_range_select,
  // Measurement inputs, same clock domain
  input wire logic [CUR_W-1:0] mean_current_value,
  input wire logic signed [CUR_W-1:0] sense_voltage,
  input wire logic protection_change,
  input wire logic calib_done,
  input wire logic enter_deep_idle_cmd,
  // Host link pins, asynchronous
  input wire logic link_activity,
  input wire logic single_wire_mode,
  // Status and controls
  output logic [1:0] power_state,
  output logic deep_idle_flag,
  output logic hf_osc_enable,
  output logic calib_start,
  output logic measure_strobe,
  output logic wake_event,
  output logic link_hold_low,
  output logic link_hold_oe,
  output logic msg_drop
);
  // ----------------------------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------------------------
  initial begin
    if (PERIOD_CYCLES < 2 || STRETCH_CYCLES < 1) $error("bad params");
  end

  logic rst_s1_q, rst_n;
  logic act_s1_q, act_s2_q, act_s3_q;
  logic act_pulse;

  // Reset released through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Link activity crosses in on two flops, edge taken after them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_s1_q <= 1'b0;
      act_s2_q <= 1'b0;
      act_s3_q <= 1'b0;
    end else begin
      act_s1_q <= link_activity;
      act_s2_q <= act_s1_q;
      act_s3_q <= act_s2_q;
    end
  end
  assign act_pulse = act_s2_q & ~act_s3_q;

  // ----------------------------------------------------------
  // Wake comparator
  // ----------------------------------------------------------
  logic signed [CUR_W-1:0] wake_thr;
  logic wake_hit;

  // Symmetric threshold from select and range; select zero disables
  always_comb begin
    unique case ({sense_resistor_select, wake_range_select})
      3'h2: wake_thr = 16'sh0001;
      3'h3, 3'h4: wake_thr = 16'sh0002;
      3'h5, 3'h6: wake_thr = 16'sh0004;
      3'h7: wake_thr = 16'sh0008;
      default: wake_thr = 16'sh7FFF;
    endcase
    // Either direction counts
    wake_hit = (sense_resistor_select != SENSE_OFF) &&
               ((sense_voltage > wake_thr) || (sense_voltage < -wake_thr));
  end

  // ----------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------
  pm_state_t state_q;
  logic [WAIT_W-1:0] wait_q;
  logic entry_ok;
  assign entry_ok = sleep_enable && (mean_current_value < sleep_current_level);

  // Transitions; every exit lands in normal
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_NORMAL;
    end else begin
      unique case (state_q)
        ST_NORMAL: begin
          if (entry_ok) state_q <= ST_CALIB;
        end
        ST_CALIB: begin
          if (!entry_ok) state_q <= ST_NORMAL;
          else if (calib_done) state_q <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (!entry_ok || protection_change || wake_hit) begin
            state_q <= ST_NORMAL;
          end else if (deep_idle_wait != WAIT_NONE && wait_q == WAIT_NONE) begin
            state_q <= ST_DEEP;
          end
        end
        ST_DEEP: begin
          if (act_pulse || !entry_ok || protection_change || wake_hit) begin
            state_q <= ST_NORMAL;
          end
        end
        default: state_q <= ST_NORMAL;
      endcase
    end
  end

  // Deep idle countdown, reloaded outside sleep
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= WAIT_NONE;
    end else if (state_q != ST_SLEEP) begin
      wait_q <= deep_idle_wait;
    end else if (wait_q != WAIT_NONE) begin
      wait_q <= wait_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------
  // Measurement pacing
  // ----------------------------------------------------------
  logic [31:0] per_q;
  logic per_tick;
  assign per_tick = (per_q == 32'(PERIOD_CYCLES - 1));

  // Free-running period counter for sleep and deep idle wake-ups
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) per_q <= 32'h0000_0000;
    else if (per_tick) per_q <= 32'h0000_0000;
    else per_q <= per_q + 32'h0000_0001;
  end

  // Normal measures every cycle; low-power states only on the tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) measure_strobe <= 1'b0;
    else if (state_q == ST_NORMAL) measure_strobe <= 1'b1;
    else measure_strobe <= per_tick && (state_q != ST_CALIB);
  end

  // ----------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------
  // Encoded state, oscillator gate, calibration request, wake pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= 2'h0;
      hf_osc_enable <= 1'b1;
      calib_start <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      power_state <= (state_q == ST_DEEP) ? 2'h2 :
                     (state_q == ST_SLEEP) ? 2'h1 : 2'h0;
      hf_osc_enable <= (state_q != ST_DEEP);
      calib_start <= (state_q == ST_NORMAL) && entry_ok;
      wake_event <= wake_hit && (state_q == ST_SLEEP || state_q == ST_DEEP);
    end
  end

  // Flag: command or automatic entry sets it; activity clears, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) deep_idle_flag <= 1'b0;
    else if (enter_deep_idle_cmd || state_q == ST_DEEP) deep_idle_flag <= 1'b1;
    else if (act_pulse) deep_idle_flag <= 1'b0;
  end

  // ----------------------------------------------------------
  // Link stretch while waking from deep idle
  // ----------------------------------------------------------
  logic [31:0] str_q;
  // Hold the line low while the core restarts, bounded by the limit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      str_q <= 32'h0000_0000;
      link_hold_low <= 1'b0;
      link_hold_oe <= 1'b0;
      msg_drop <= 1'b0;
    end else begin
      msg_drop <= 1'b0;
      if (state_q == ST_DEEP && act_pulse) begin
        str_q <= 32'(STRETCH_CYCLES - 1);
        link_hold_oe <= 1'b1;
        msg_drop <= single_wire_mode;
      end else if (str_q != 32'h0000_0000) begin
        str_q <= str_q - 32'h0000_0001;
      end else begin
        link_hold_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_deep_osc_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_DEEP |=> !hf_osc_enable) else $error("osc running in deep idle");
  chk_zero_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && deep_idle_wait == WAIT_NONE) |=> state_q != ST_DEEP)
    else $error("deep idle with zero wait");
  chk_deep_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEEP && act_pulse) |=> state_q == ST_NORMAL) else $error("no deep exit");
  chk_sleep_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && protection_change) |=> state_q == ST_NORMAL)
    else $error("no sleep exit");
  chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(state_q == ST_SLEEP) |-> $past(state_q == ST_CALIB) && $past(entry_ok))
    else $error("sleep without calibration");
  chk_comp_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sense_resistor_select == SENSE_OFF |=> !wake_event) else $error("comparator not off");
  chk_stretch_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (str_q == 32'h0000_0001) |=> ##1 !link_hold_oe) else $error("stretch overran");
  chk_normal_meas: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q == ST_NORMAL |=> measure_strobe) else $error("normal not measuring");

  // ----------------------------------------------------------
  // Checks on state code, entry, pacing, exit, oscillator, flag and link outputs
  // ----------------------------------------------------------
  // Encoded state never shows the unused code
  chk_three_states: assert property (@(posedge sys_clk) disable iff (!rst_n)
    power_state != 2'h3) else $error("illegal power state code");
  // Normal stays put while entry is not qualified
  chk_normal_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_NORMAL && !entry_ok) |=> state_q == ST_NORMAL)
    else $error("left normal unqualified");
  // Qualification always passes through calibration first
  chk_calib_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_NORMAL && entry_ok) |=> state_q == ST_CALIB)
    else $error("calibration skipped");
  // Losing qualification during calibration aborts the entry
  chk_calib_abort: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_CALIB && !entry_ok) |=> state_q == ST_NORMAL)
    else $error("calibration not aborted");
  // Sleep measures on every period tick
  chk_sleep_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && per_tick) |=> measure_strobe)
    else $error("sleep wake-up missed");
  // Deep idle stays quiet between ticks, which is where the power goes down
  chk_deep_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEEP && !per_tick) |=> !measure_strobe)
    else $error("deep idle not idle");
  // Expired countdown with nonzero wait moves sleep into deep idle
  chk_deep_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && entry_ok && !protection_change && !wake_hit &&
     deep_idle_wait != WAIT_NONE && wait_q == WAIT_NONE) |=> state_q == ST_DEEP)
    else $error("countdown did not reach deep idle");
  // Broken entry condition ends sleep
  chk_low_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_SLEEP && !entry_ok) |=> state_q == ST_NORMAL)
    else $error("sleep held without qualification");
  // Oscillator back on in every state but deep idle
  chk_osc_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_q != ST_DEEP |=> hf_osc_enable) else $error("osc off outside deep idle");
  // Command always sets the flag on the next edge
  chk_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enter_deep_idle_cmd |=> deep_idle_flag) else $error("flag not set");
  // Single-wire wake marks the lost message for one cycle
  chk_drop_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q == ST_DEEP && act_pulse && single_wire_mode) |=> msg_drop ##1 !msg_drop)
    else $error("message drop not flagged");
  // Comparator trip in deep idle is reported as well
  chk_wake_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wake_hit && state_q == ST_DEEP) |=> wake_event) else $error("wake trip lost");
  // Driven line value is always low while the stretch holds it
  chk_hold_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    link_hold_oe |-> !link_hold_low) else $error("stretch drives high");
endmodule

// *** test/host_link_model.sv ***
// Host processor model on the far side of the link
`timescale 1ns/1ps
module host_link_model (
  // Clock
  input wire logic sys_clk,
  // Bench control
  input wire logic send,
  // Gauge side of the link
  input wire logic link_hold_oe,
  input wire logic msg_drop,
  output logic link_activity,
  output int sent_count,
  output int stretch_seen
);
  logic drop_q;
  // ----
  // Link traffic
  // ----
  initial begin
    link_activity = 1'b0;
    sent_count = 0;
    stretch_seen = 0;
    drop_q = 1'b0;
  end
  // Tolerate the gauge holding the line low
  always @(posedge sys_clk) begin
    if (link_hold_oe) stretch_seen++;
    if (msg_drop) drop_q = 1'b1;
  end
  // One message is a short burst of line activity
  task automatic frame();
    @(negedge sys_clk) link_activity = 1'b1;
    repeat (3) @(negedge sys_clk);
    link_activity = 1'b0;
    sent_count++;
  endtask
  // Resend once the stretch ends if the wake ate the message
  always @(posedge send) begin
    frame();
    repeat (8) @(negedge sys_clk);
    while (link_hold_oe) @(negedge sys_clk);
    if (drop_q) begin
      drop_q = 1'b0;
      frame();
    end
  end
endmodule

// *** test/tb_gauge_power_mode_control.sv ***
// Self-checking bench for the gauge power-mode controller
`timescale 1ns/1ps
module tb_gauge_power_mode_control;
  import gauge_pm_pkg::*;
  logic sys_clk = 0, nrst = 0, sleep_enable = 0, wake_range_select = 0;
  logic protection_change = 0, calib_done = 0, enter_deep_idle_cmd = 0;
  logic single_wire_mode = 0, send = 0, link_activity;
  logic [CUR_W-1:0] sleep_current_level = 16'h0100, mean_current_value = 16'h0100;
  logic signed [CUR_W-1:0] sense_voltage = 16'h0000;
  logic [WAIT_W-1:0] deep_idle_wait = WAIT_NONE;
  logic [1:0] sense_resistor_select = 2'h1, power_state, prev = 2'h0;
  logic deep_idle_flag, hf_osc_enable, calib_start, measure_strobe;
  logic wake_event, link_hold_low, link_hold_oe, msg_drop;
  logic [1:0] q[$];
  int fails = 0, tests_run = 0, seed = 55, cyc = 0, sent_count, stretch_seen, cnt;
  always #4 sys_clk = ~sys_clk;
  gauge_power_mode_control #(.STRETCH_CYCLES(10), .PERIOD_CYCLES(8)) gauge_power_mode_control_inst (
    .sys_clk(sys_clk), .nrst(nrst), .sleep_enable(sleep_enable),
    .sleep_current_level(sleep_current_level), .deep_idle_wait(deep_idle_wait),
    .sense_resistor_select(sense_resistor_select), .wake_range_select(wake_range_select),
    .mean_current_value(mean_current_value), .sense_voltage(sense_voltage),
    .protection_change(protection_change), .calib_done(calib_done),
    .enter_deep_idle_cmd(enter_deep_idle_cmd), .link_activity(link_activity),
    .single_wire_mode(single_wire_mode), .power_state(power_state),
    .deep_idle_flag(deep_idle_flag), .hf_osc_enable(hf_osc_enable),
    .calib_start(calib_start), .measure_strobe(measure_strobe), .wake_event(wake_event),
    .link_hold_low(link_hold_low), .link_hold_oe(link_hold_oe), .msg_drop(msg_drop));
  host_link_model host_link_model_inst (.sys_clk(sys_clk), .send(send),
    .link_hold_oe(link_hold_oe), .msg_drop(msg_drop), .link_activity(link_activity),
    .sent_count(sent_count), .stretch_seen(stretch_seen));
  // ----
  // Checking helpers
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Every state change must match the oldest note; 3 marks an unplanned one
  always @(negedge sys_clk) begin
    if (nrst && power_state !== prev) begin
      prev = power_state;
      check(power_state, q.size() ? q.pop_front() : 2'h3);
    end
  end
  // Hang guard, far above the planned run length
  always @(posedge sys_clk) if (++cyc == 5000) begin
    fails++;
    results();
  end
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // Count measurement strobes over a window
  task automatic strobes(input int len);
    cnt = 0;
    repeat (len) @(negedge sys_clk) cnt += measure_strobe;
  endtask
  // Qualify sleep with a random current below the level, then finish calibration
  task automatic go_sleep();
    int n;
    n = 0;
    sleep_enable = 1;
    mean_current_value = ($random(seed) & 16'h00FF);
    while (calib_start !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check(calib_start, 1);
    check(power_state, 0);
    q.push_back(2'h1);
    calib_done = 1;
    @(negedge sys_clk) calib_done = 0;
    wait_state(2'h1);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (16) @(negedge sys_clk);
    nrst = 1;
    repeat (4) @(negedge sys_clk);
    check({hf_osc_enable, measure_strobe}, 2'h3);
    // Enable off, then current equal to the level: both refused
    mean_current_value = 16'h0010;
    repeat (40) @(negedge sys_clk);
    sleep_enable = 1;
    mean_current_value = sleep_current_level;
    repeat (40) @(negedge sys_clk);
    check(calib_start, 0);
    // Each exit cause brings sleep back to normal
    for (int i = 0; i < 4; i++) begin
      if (i == 0) begin
        sense_resistor_select = SENSE_OFF;
        sense_voltage = -16'sd100;
      end
      go_sleep();
      if (i == 0) begin
        strobes(60);
        check((cnt >= 6 && cnt <= 8), 1);
        check(power_state, 1);
        sense_voltage = 16'h0000;
        sense_resistor_select = 2'h1 + 2'($unsigned($random(seed)) % 3);
        wake_range_select = $random(seed);
      end
      q.push_back(2'h0);
      case (i)
        0: sleep_enable = 0;
        1: mean_current_value = sleep_current_level;
        2: protection_change = 1;
        default: sense_voltage = -16'sd9 - ($random(seed) & 7);
      endcase
      @(negedge sys_clk) protection_change = 0;
      if (i == 3) check(wake_event, 1);
      wait_state(2'h0);
      check(power_state, 0);
      sleep_enable = 0;
      sense_voltage = 16'h0000;
      repeat (4) @(negedge sys_clk);
    end
    // Countdown into deep idle, command flag, host wake
    deep_idle_wait = 16'h0010;
    go_sleep();
    q.push_back(2'h2);
    wait_state(2'h2);
    repeat (2) @(negedge sys_clk);
    check(hf_osc_enable, 0);
    strobes(40);
    check((cnt >= 4 && cnt <= 6), 1);
    enter_deep_idle_cmd = 1;
    @(negedge sys_clk) enter_deep_idle_cmd = 0;
    @(negedge sys_clk) check(deep_idle_flag, 1);
    single_wire_mode = 1;
    q.push_back(2'h0);
    send = 1;
    @(negedge sys_clk) send = 0;
    wait_state(2'h0);
    sleep_enable = 0;
    repeat (60) @(negedge sys_clk);
    check(deep_idle_flag, 0);
    check(stretch_seen > 0, 1);
    check(link_hold_low, 0);
    check(sent_count, 2);
    check(q.size(), 0);
    results();
  end
endmodule
